// *** inc/transceive_pkg.sv ***
// shared constants and types for the transceive configuration block
package transceive_pkg;
  // register index as printed, byte address is four times it
  localparam logic [5:0] TCFG_INDEX = 6'h04;
  localparam logic [7:0] ADR_TCFG = {TCFG_INDEX, 2'b00};
  localparam logic [7:0] ADR_IRQ_STATUS = 8'h40;
  localparam logic [7:0] ADR_IRQ_ENABLE = 8'h44;
  localparam logic [7:0] ADR_IRQ_CLEAR = 8'h48;
  localparam logic [7:0] ADR_STATE = 8'h4C;

  // configuration field positions
  localparam int unsigned TRIG_LSB = 4;
  localparam int unsigned TRIG_W = 6;
  localparam int unsigned SKIP_BIT = 3;
  localparam int unsigned PERBYTE_BIT = 2;
  localparam int unsigned MULTI_BIT = 1;
  localparam int unsigned INIT_BIT = 0;
  localparam logic [31:0] TCFG_RESET = 32'h0000_0000;

  // interrupt bits
  localparam int unsigned IRQ_W = 4;
  localparam int unsigned IRQ_STATE_CHANGE = 0;
  localparam int unsigned IRQ_TX_START = 1;
  localparam int unsigned IRQ_TX_SKIPPED = 2;
  localparam int unsigned IRQ_RX_STORED = 3;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 4'h0;

  // state readback field positions
  localparam int unsigned STATE_SEQ_LSB = 0;
  localparam int unsigned STATE_PAUSE_BIT = 4;
  localparam int unsigned STATE_ADDR_LSB = 16;

  localparam int unsigned RAM_ADDR_W = 9;
  localparam logic [7:0] PAD_BYTE = 8'h00;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_WAIT_SEND,
    ST_TX,
    ST_WAIT_RX,
    ST_WAIT_DATA,
    ST_RX
  } seq_state_e;

  typedef struct packed {
    logic [5:0] trig;
    logic skip;
    logic per_byte;
    logic multi;
    logic initiator;
  } tcfg_s;

  typedef struct packed {
    logic we;
    logic [RAM_ADDR_W-1:0] addr;
    logic [31:0] data;
  } ram_wr_s;
endpackage

// *** hdl/frame_word_packer.sv ***
// packs received bytes into word-aligned ram writes with optional status byte
`timescale 1ns/10ps
module frame_word_packer (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic restart,
  input wire logic byte_valid,
  input wire logic [7:0] byte_data,
  input wire logic frame_end,
  input wire logic [7:0] status_byte,
  input wire logic status_en,
  output transceive_pkg::ram_wr_s ram_wr
);
  logic [1:0] lane_q;
  logic [31:0] word_q;
  logic [transceive_pkg::RAM_ADDR_W-1:0] addr_q;
  transceive_pkg::ram_wr_s wr_q;
  logic [7:0] byte_in;
  logic [31:0] merged;

  assign byte_in = byte_valid ? byte_data : status_byte;
  assign merged = word_q | ({24'h000000, byte_in} << {lane_q, 3'b000});

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      lane_q <= 2'h0;
      word_q <= 32'h0000_0000;
      addr_q <= '0;
      wr_q <= '0;
    end else begin
      wr_q.we <= 1'b0;
      if (restart) begin
        lane_q <= 2'h0;
        word_q <= 32'h0000_0000;
        addr_q <= '0;
      end else if (byte_valid) begin
        if (lane_q == 2'h3) begin
          wr_q.we <= 1'b1;
          wr_q.addr <= addr_q;
          wr_q.data <= merged;
          word_q <= 32'h0000_0000;
          addr_q <= addr_q + 1'b1;
        end else begin
          word_q <= merged;
        end
        lane_q <= lane_q + 2'h1;
      end else if (frame_end) begin
        if (status_en || lane_q != 2'h0) begin
          wr_q.we <= 1'b1;
          wr_q.addr <= addr_q;
          wr_q.data <= status_en ? merged : word_q;
          addr_q <= addr_q + 1'b1;
        end
        word_q <= {4{transceive_pkg::PAD_BYTE}};
        lane_q <= 2'h0;
      end
    end
  end

  assign ram_wr = wr_q;
endmodule

// *** hdl/transceive_control_config.sv ***
// transceive configuration register, sequencer controls and interrupt logic
`timescale 1ns/10ps
module transceive_control_config (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [7:0] wb_adr,
  input wire logic [3:0] wb_sel,
  input wire logic [31:0] wb_dat_w,
  output logic [31:0] wb_dat_r,
  output logic wb_ack,
  input transceive_pkg::seq_state_e seq_state,
  input wire logic tx_wait_expired,
  input wire logic send_request,
  input wire logic tx_byte_done,
  output logic tx_start,
  output logic encoder_paused,
  output logic per_byte_framing_bit,
  input wire logic rx_buf_restart,
  input wire logic rx_byte_valid,
  input wire logic [7:0] rx_byte,
  input wire logic rx_end,
  input wire logic [7:0] rx_status,
  output logic rx_rearm,
  output logic multiple_reception_bit,
  output transceive_pkg::ram_wr_s ram_wr,
  output logic initiator_mode,
  output logic irq
);
  transceive_pkg::tcfg_s tcfg_q;
  transceive_pkg::tcfg_s tcfg_d;
  transceive_pkg::seq_state_e prev_state_q;
  logic [transceive_pkg::IRQ_W-1:0] irq_status_q;
  logic [transceive_pkg::IRQ_W-1:0] irq_enable_q;
  logic [transceive_pkg::IRQ_W-1:0] irq_event;
  logic [transceive_pkg::IRQ_W-1:0] irq_clear;
  logic [31:0] clear_word;
  logic [31:0] enable_word;
  logic [31:0] cfg_word;
  logic [31:0] state_word;
  logic [31:0] rd_mux;
  logic [31:0] dat_r_q;
  logic ack_q;
  logic bus_req;
  logic wr_tcfg;
  logic wr_enable;
  logic wr_clear;
  logic state_entered;
  logic state_hit;
  logic [2:0] state_idx;
  logic start_trigger;
  logic tx_start_q;
  logic skipped;
  logic paused_q;
  logic rearm_q;
  logic rx_stored;

  function automatic logic [31:0] merge_bytes(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0] sel
  );
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // wishbone classic slave, one wait state per access
  assign bus_req = wb_cyc & wb_stb & ~ack_q;
  assign wr_tcfg = bus_req & wb_we & (wb_adr == transceive_pkg::ADR_TCFG);
  assign wr_enable = bus_req & wb_we & (wb_adr == transceive_pkg::ADR_IRQ_ENABLE);
  assign wr_clear = bus_req & wb_we & (wb_adr == transceive_pkg::ADR_IRQ_CLEAR);

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= bus_req;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      dat_r_q <= 32'h0000_0000;
    end else if (bus_req && !wb_we) begin
      dat_r_q <= rd_mux;
    end
  end

  assign wb_ack = ack_q;
  assign wb_dat_r = dat_r_q;

  // configuration register image
  always_comb begin
    cfg_word = 32'h0000_0000;
    cfg_word[transceive_pkg::TRIG_LSB +: transceive_pkg::TRIG_W] = tcfg_q.trig;
    cfg_word[transceive_pkg::SKIP_BIT] = tcfg_q.skip;
    cfg_word[transceive_pkg::PERBYTE_BIT] = tcfg_q.per_byte;
    cfg_word[transceive_pkg::MULTI_BIT] = tcfg_q.multi;
    cfg_word[transceive_pkg::INIT_BIT] = tcfg_q.initiator;
  end

  // own state readback
  always_comb begin
    state_word = 32'h0000_0000;
    state_word[transceive_pkg::STATE_SEQ_LSB +: 3] = seq_state;
    state_word[transceive_pkg::STATE_PAUSE_BIT] = paused_q;
    state_word[transceive_pkg::STATE_ADDR_LSB +: transceive_pkg::RAM_ADDR_W] = ram_wr.addr;
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (wb_adr)
      transceive_pkg::ADR_TCFG: begin
        rd_mux = cfg_word;
      end
      transceive_pkg::ADR_IRQ_STATUS: begin
        rd_mux[transceive_pkg::IRQ_W-1:0] = irq_status_q;
      end
      transceive_pkg::ADR_IRQ_ENABLE: begin
        rd_mux[transceive_pkg::IRQ_W-1:0] = irq_enable_q;
      end
      transceive_pkg::ADR_STATE: begin
        rd_mux = state_word;
      end
      default: begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  // next configuration from a byte-lane write
  always_comb begin
    logic [31:0] w;
    w = merge_bytes(cfg_word, wb_dat_w, wb_sel);
    tcfg_d.trig = w[transceive_pkg::TRIG_LSB +: transceive_pkg::TRIG_W];
    tcfg_d.skip = w[transceive_pkg::SKIP_BIT];
    tcfg_d.per_byte = w[transceive_pkg::PERBYTE_BIT];
    tcfg_d.multi = w[transceive_pkg::MULTI_BIT];
    tcfg_d.initiator = w[transceive_pkg::INIT_BIT];
  end

  // sequencer state entry detection
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      prev_state_q <= transceive_pkg::ST_IDLE;
    end else begin
      prev_state_q <= seq_state;
    end
  end

  assign state_entered = (seq_state != prev_state_q);
  assign state_idx = seq_state;

  // trigger bit index follows state order
  // all six trigger bits follow state order, ST_IDLE at bit 0
  always_comb begin
    state_hit = 1'b0;
    if (state_entered && state_idx < 3'h6) begin
      state_hit = tcfg_q.trig[state_idx];
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      tcfg_q <= transceive_pkg::tcfg_s'(transceive_pkg::TCFG_RESET[9:0]);
    end else if (wr_tcfg) begin
      tcfg_q <= tcfg_d;
    end else if (state_entered && seq_state == transceive_pkg::ST_WAIT_RX) begin
      tcfg_q.skip <= 1'b0;
    end
  end

  // transmit start and skip-send gating
  assign start_trigger = tx_wait_expired & send_request;
  assign skipped = start_trigger & tcfg_q.skip;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      tx_start_q <= 1'b0;
    end else begin
      tx_start_q <= start_trigger & ~tcfg_q.skip;
    end
  end

  // pause per byte until next transmit start that is not skipped
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      paused_q <= 1'b0;
    end else if (tx_start_q) begin
      paused_q <= 1'b0;
    end else if (tx_byte_done && tcfg_q.per_byte) begin
      paused_q <= 1'b1;
    end
  end

  assign tx_start = tx_start_q;
  assign encoder_paused = paused_q;
  assign per_byte_framing_bit = tcfg_q.per_byte;

  assign rx_stored = rx_end & tcfg_q.multi;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rearm_q <= 1'b0;
    end else begin
      rearm_q <= rx_stored;
    end
  end

  assign rx_rearm = rearm_q;
  assign multiple_reception_bit = tcfg_q.multi;

  // status byte appended in multi mode
  frame_word_packer packer (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .restart(rx_buf_restart),
    .byte_valid(rx_byte_valid),
    .byte_data(rx_byte),
    .frame_end(rx_end),
    .status_byte(rx_status),
    .status_en(tcfg_q.multi),
    .ram_wr(ram_wr)
  );

  assign initiator_mode = tcfg_q.initiator;

  // interrupt events, set wins over clear
  always_comb begin
    irq_event = '0;
    irq_event[transceive_pkg::IRQ_STATE_CHANGE] = state_hit;
    irq_event[transceive_pkg::IRQ_TX_START] = start_trigger & ~tcfg_q.skip;
    irq_event[transceive_pkg::IRQ_TX_SKIPPED] = skipped;
    irq_event[transceive_pkg::IRQ_RX_STORED] = rx_stored;
  end

  assign clear_word = merge_bytes(32'h0000_0000, wb_dat_w, wb_sel);
  assign enable_word = merge_bytes({28'h0000000, irq_enable_q}, wb_dat_w, wb_sel);
  assign irq_clear = wr_clear ? clear_word[transceive_pkg::IRQ_W-1:0] : '0;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      irq_status_q <= transceive_pkg::IRQ_RESET;
    end else begin
      irq_status_q <= (irq_status_q & ~irq_clear) | irq_event;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      irq_enable_q <= transceive_pkg::IRQ_RESET;
    end else if (wr_enable) begin
      irq_enable_q <= enable_word[transceive_pkg::IRQ_W-1:0];
    end
  end

  assign irq = |(irq_status_q & irq_enable_q);
endmodule

// *** sim/transceive_control_config_monitor.sv ***
// concurrent checks on the transceive configuration block ports
`timescale 1ns/10ps
module transceive_control_config_monitor (
  input logic clk_sys,
  input logic arst_n,
  input logic wb_cyc,
  input logic wb_stb,
  input logic wb_we,
  input logic wb_ack,
  input logic tx_wait_expired,
  input logic send_request,
  input logic tx_byte_done,
  input logic tx_start,
  input logic encoder_paused,
  input logic per_byte_framing_bit,
  input logic rx_byte_valid,
  input logic rx_end,
  input logic rx_rearm,
  input logic multiple_reception_bit,
  input transceive_pkg::ram_wr_s ram_wr,
  input logic initiator_mode
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);
  sequence rx_close;
    multiple_reception_bit && rx_end && !rx_byte_valid;
  endsequence
  sequence cfg_write;
    wb_ack && wb_we;
  endsequence
  AST_RESET_ZERO: assert property ($rose(arst_n) |-> !initiator_mode && !multiple_reception_bit)
    else $error("config outputs not zero after reset");
  AST_ACK_NEXT: assert property (wb_cyc && wb_stb && !wb_ack |=> wb_ack)
    else $error("register access not answered in one cycle");
  AST_TX_CAUSE: assert property (tx_start |-> $past(tx_wait_expired) && $past(send_request))
    else $error("transmit start without guard wait and send request");
  AST_PAUSE_SET: assert property (per_byte_framing_bit && tx_byte_done && !tx_start |=> encoder_paused)
    else $error("encoder did not pause after byte");
  AST_PAUSE_CLR: assert property (tx_start && !tx_byte_done |=> !encoder_paused)
    else $error("encoder pause not cleared by start");
  AST_REARM: assert property (rx_close |=> rx_rearm && ram_wr.we)
    else $error("no rearm or status word after frame end");
  AST_REARM_CAUSE: assert property (rx_rearm |-> $past(rx_end) && $past(multiple_reception_bit))
    else $error("rearm without multiple reception frame end");
  AST_ROLE_HOLD: assert property ($changed(initiator_mode) |-> cfg_write)
    else $error("role changed without register write");
  AST_FRAME_HOLD: assert property ($changed(per_byte_framing_bit) |-> cfg_write)
    else $error("per byte framing changed without register write");
endmodule
bind transceive_control_config transceive_control_config_monitor i_transceive_control_config_monitor (
  .clk_sys(clk_sys), .arst_n(arst_n), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we), .wb_ack(wb_ack),
  .tx_wait_expired(tx_wait_expired), .send_request(send_request), .tx_byte_done(tx_byte_done),
  .tx_start(tx_start), .encoder_paused(encoder_paused), .per_byte_framing_bit(per_byte_framing_bit),
  .rx_byte_valid(rx_byte_valid), .rx_end(rx_end), .rx_rearm(rx_rearm),
  .multiple_reception_bit(multiple_reception_bit), .ram_wr(ram_wr), .initiator_mode(initiator_mode)
);

// *** sim/transceive_control_config_test.sv ***
// self-checking bench for the transceive configuration block
`timescale 1ns/10ps
module transceive_control_config_test;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, wb_ack;
  logic [7:0] wb_adr = 8'h00, rx_byte = 8'h00, rx_status = 8'h00;
  logic [3:0] wb_sel = 4'h0;
  logic [31:0] wb_dat_w = 32'h0, wb_dat_r, rd, wv;
  transceive_pkg::seq_state_e seq_state = transceive_pkg::ST_IDLE;
  logic tx_wait_expired = 1'b0, send_request = 1'b0, tx_byte_done = 1'b0, rx_buf_restart = 1'b0;
  logic rx_byte_valid = 1'b0, rx_end = 1'b0;
  logic tx_start, encoder_paused, per_byte_framing_bit, rx_rearm, multiple_reception_bit, initiator_mode, irq;
  transceive_pkg::ram_wr_s ram_wr;
  transceive_pkg::ram_wr_s wq[$], eq[$];
  logic [7:0] bq[$];
  logic [5:0] t;
  logic [8:0] ea;
  int bad_count = 0, total_checks = 0, cycles = 0, seed = 32'hFBAF;
  always #25 clk_sys = ~clk_sys;
  transceive_control_config i_transceive_control_config (
    .clk_sys(clk_sys), .arst_n(arst_n), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr),
    .wb_sel(wb_sel), .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack), .seq_state(seq_state),
    .tx_wait_expired(tx_wait_expired), .send_request(send_request), .tx_byte_done(tx_byte_done),
    .tx_start(tx_start), .encoder_paused(encoder_paused), .per_byte_framing_bit(per_byte_framing_bit),
    .rx_buf_restart(rx_buf_restart), .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte), .rx_end(rx_end),
    .rx_status(rx_status), .rx_rearm(rx_rearm), .multiple_reception_bit(multiple_reception_bit),
    .ram_wr(ram_wr), .initiator_mode(initiator_mode), .irq(irq)
  );
  always @(posedge clk_sys) begin
    cycles++;
    if (ram_wr.we === 1'b1) wq.push_back(ram_wr);
    if (cycles == 20000) begin
      bad_count++;
      summarize();
    end
  end
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_sel <= s;
    wb_dat_w <= d;
    do @(posedge clk_sys); while (wb_ack !== 1'b1);
    rd = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
    @(posedge clk_sys);
  endtask
  // expected ram words of one frame: status byte in multi mode, then zero padding to a word
  function automatic void expect_frame(input logic m, input logic [7:0] st);
    if (m) bq.push_back(st);
    while (bq.size() % 4 != 0) bq.push_back(8'h00);
    while (bq.size() > 0) begin
      eq.push_back({1'b1, ea, bq[3], bq[2], bq[1], bq[0]});
      ea++;
      repeat (4) void'(bq.pop_front());
    end
  endfunction
  task automatic frame(input int n, input logic m);
    logic [7:0] b;
    for (int i = 0; i < n; i++) begin
      b = $random(seed);
      bq.push_back(b);
      rx_byte_valid <= 1'b1;
      rx_byte <= b;
      @(posedge clk_sys);
    end
    b = $random(seed);
    rx_byte_valid <= 1'b0;
    rx_end <= 1'b1;
    rx_status <= b;
    @(posedge clk_sys);
    rx_end <= 1'b0;
    repeat (3) @(posedge clk_sys);
    expect_frame(m, b);
  endtask
  initial begin
    repeat (6) @(posedge clk_sys);
    arst_n <= 1'b1;
    @(posedge clk_sys);
    wb(0, transceive_pkg::ADR_TCFG, 0);
    check("cfg_reset", rd, 0);
    wb(1, 8'hFC, 32'hFFFF_FFFF);
    wb(0, 8'hFC, 0);
    check("unmapped", rd, 0);
    wb(1, transceive_pkg::ADR_TCFG, 32'h3FF, 4'h1);
    wb(0, transceive_pkg::ADR_TCFG, 0);
    check("lane_merge", rd, 32'hFF);
    repeat (12) begin
      wv = $random(seed);
      wb(1, transceive_pkg::ADR_TCFG, wv);
      wb(0, transceive_pkg::ADR_TCFG, 0);
      check("cfg", rd, {22'h0, wv[9:0]});
      check("role", initiator_mode, wv[0]);
      check("multi", multiple_reception_bit, wv[1]);
      check("per_byte", per_byte_framing_bit, wv[2]);
    end
    $display("test config done");
    wb(1, transceive_pkg::ADR_IRQ_ENABLE, 1);
    for (int k = 0; k < 8; k++) begin
      t = (k < 6) ? 6'h01 << k : (k == 6) ? 6'h00 : 6'($random(seed));
      wb(1, transceive_pkg::ADR_TCFG, {22'h0, t, 4'h0});
      wb(1, transceive_pkg::ADR_IRQ_CLEAR, 1);
      for (int s = 1; s < 7; s++) begin
        seq_state <= transceive_pkg::seq_state_e'(s % 6);
        @(posedge clk_sys);
        wb(0, transceive_pkg::ADR_IRQ_STATUS, 0);
        check("state_flag", rd[0], t[s % 6]);
        check("irq_pin", irq, t[s % 6]);
        wb(1, transceive_pkg::ADR_IRQ_CLEAR, 1);
      end
    end
    $display("test state trigger done");
    wb(1, transceive_pkg::ADR_IRQ_ENABLE, 0);
    for (int k = 0; k < 2; k++) begin
      wb(1, transceive_pkg::ADR_TCFG, {28'h0, k[0], 3'b100});
      tx_byte_done <= 1'b1;
      @(posedge clk_sys);
      tx_byte_done <= 1'b0;
      @(posedge clk_sys);
      check("paused", encoder_paused, 1);
      tx_wait_expired <= 1'b1;
      send_request <= 1'b1;
      @(posedge clk_sys);
      tx_wait_expired <= 1'b0;
      @(posedge clk_sys);
      check("tx_start", tx_start, !k);
      send_request <= 1'b0;
      @(posedge clk_sys);
      check("resume", encoder_paused, k);
      wb(0, transceive_pkg::ADR_IRQ_STATUS, 0);
      check("skip_flag", rd[2], k);
      check("irq_masked", irq, 0);
      wb(1, transceive_pkg::ADR_IRQ_ENABLE, 4);
      check("irq_enabled", irq, k);
      wb(1, transceive_pkg::ADR_IRQ_CLEAR, 4);
      wb(1, transceive_pkg::ADR_IRQ_ENABLE, 0);
      check("irq_cleared", irq, 0);
      seq_state <= transceive_pkg::ST_WAIT_RX;
      @(posedge clk_sys);
      seq_state <= transceive_pkg::ST_IDLE;
      wb(0, transceive_pkg::ADR_TCFG, 0);
      check("skip_auto_clear", rd[3], 0);
    end
    $display("test transmit done");
    for (int m = 0; m < 2; m++) begin
      wb(1, transceive_pkg::ADR_TCFG, {30'h0, m[0], 1'b0});
      rx_buf_restart <= 1'b1;
      @(posedge clk_sys);
      rx_buf_restart <= 1'b0;
      @(posedge clk_sys);
      wq.delete();
      eq.delete();
      ea = 9'h000;
      frame(2, m[0]);
      frame(4, m[0]);
      frame(5, m[0]);
      frame(3, m[0]);
      check("ram_words", wq.size(), eq.size());
      if (wq.size() == eq.size()) foreach (eq[i]) check("ram_word", wq[i], eq[i]);
      wb(0, transceive_pkg::ADR_IRQ_STATUS, 0);
      check("stored_flag", rd[3], m);
      wb(1, transceive_pkg::ADR_IRQ_CLEAR, 32'hF);
    end
    wb(0, transceive_pkg::ADR_STATE, 0);
    check("state_word", rd[15:0], {11'h000, 1'b1, 4'h0});
    $display("test reception done");
    summarize();
  end
endmodule
